// file: sdadc_pkg.sv
// Constants and types shared by the converter sequencer and its result store.
// Assumes one clock domain; offsets are Avalon byte addresses.

package sdadc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [5:0] OFS_DATA0 = 6'h00;
	localparam logic [5:0] OFS_DATA1 = 6'h08;
	localparam logic [5:0] OFS_DATA2 = 6'h10;
	localparam logic [5:0] OFS_DATA3 = 6'h18;
	localparam logic [5:0] OFS_CSR = 6'h20;
	localparam logic [5:0] OFS_DIV = 6'h30;
	localparam logic [5:0] OFS_PWR = 6'h38;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CSR_OVR_BIT = 13;
	localparam int CSR_IE_LSB = 8;
	localparam int CSR_SINGLE_BIT = 6;
	localparam int CSR_SEL_LSB = 4;
	localparam int CSR_DA_LSB = 0;
	localparam int PWR_BIT = 0;

	// ****************************************
	// Reset values and sizes
	// ****************************************
	localparam int NUM_CH = 4;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [11:0] DIV_RST = 12'h005;
	localparam logic [11:0] DIV_MIN = 12'h002;

	// ****************************************
	// Frame timing, in oversampling cycles
	// ****************************************
	localparam logic [8:0] FRAME_LAST = 9'h1ff;
	localparam logic [1:0] KEEP_PHASE = 2'h3;
	localparam logic [15:0] MID_SCALE = 16'h8000;

	// ****************************************
	// Bus handshake states
	// ****************************************
	typedef enum logic [1:0] {
		SDADC_BUS_IDLE = 2'b00,
		SDADC_BUS_WAIT = 2'b01,
		SDADC_BUS_DONE = 2'b10
	} sdadc_bus_state_t;

endpackage : sdadc_pkg

// file: sdadc_mem_if.sv
// Interface between the sequencer and its result store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface sdadc_mem_if;
	logic we;
	logic [1:0] waddr;
	logic [15:0] wdata;
	logic [1:0] raddr;
	logic [15:0] rdata;

	// Sequencer side
	modport owner (output we, output waddr, output wdata, output raddr,
		input rdata);
	// Store side
	modport store (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface : sdadc_mem_if

// file: sdadc_result_mem.sv
// Four-word store of channel results with registered read data.
// Assumes writes and reads come from logic on core_clk_in.
`timescale 1ns/1ps

module sdadc_result_mem (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Access port
	sdadc_mem_if.store store_if
);

	logic [15:0] words [sdadc_pkg::NUM_CH];

	// ****************************************
	// Storage
	// ****************************************

	// Write port, cleared by reset
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < sdadc_pkg::NUM_CH; i++) begin
				words[i] <= sdadc_pkg::DATA_RST;
			end
		end else if (store_if.we) begin
			words[store_if.waddr] <= store_if.wdata;
		end
	end

	// Registered read port
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			store_if.rdata <= sdadc_pkg::DATA_RST;
		end else begin
			store_if.rdata <= words[store_if.raddr];
		end
	end

endmodule : sdadc_result_mem

// file: sdadc_seq.sv
// Sequencer of a four-channel sigma-delta converter: divider, frames,
// channel selection, result storage, flags and Avalon-MM registers.
// Assumes the modulator bit is asynchronous and clk_stop_in is on-clock.
//
// Overview of operation
// - round-robin gives each channel one 512-cycle frame
// - first frame cycle resets modulator, clears filter
// - after 511 filtered cycles store 16-bit sample
// - round-robin advances channel each frame, endlessly
// - single mode keeps one frame of four
// - asynchronous inputs pass a two-stage synchroniser
// - oversampling clock is bus clock over 2*divider, divider below two run as two
// - divider field reads back as zero
// - divider resets to five, division by ten
// - result is signed, input minus mid-scale
// - overrun bit 13 sticky until written zero
// - enables in bits 11:8 gate channel interrupts
// - ready flags set on sample, written zero clears
// - bit 6 picks single mode, bits 5:4 channel
// - ascending order round-robin, selected channel only otherwise
// - result in bits 15:7, low seven bits zero
// - analog power control cleared by reset
// - clock gate input stops the oversampling clock only
`timescale 1ns/1ps

module sdadc_seq (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Avalon-MM slave
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Modulator
	input wire logic mod_bit_in,
	output logic mod_clk_out,
	output logic mod_reset_out,
	output logic [1:0] mod_channel_out,
	// System
	input wire logic clk_stop_in,
	output logic analog_power_out,
	output logic irq_out
);

	sdadc_mem_if mem_if ();

	sdadc_result_mem u_mem (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.store_if(mem_if.store)
	);

	// ****************************************
	// Address decoding
	// ****************************************

	// True for any of the four result registers
	function automatic logic is_data(input logic [5:0] a);
		is_data = (a == sdadc_pkg::OFS_DATA0) ||
			(a == sdadc_pkg::OFS_DATA1) ||
			(a == sdadc_pkg::OFS_DATA2) ||
			(a == sdadc_pkg::OFS_DATA3);
	endfunction : is_data

	// ****************************************
	// Registers
	// ****************************************
	sdadc_pkg::sdadc_bus_state_t bus_state;
	logic [11:0] divider, div_cnt, div_eff;
	logic [8:0] frame_cnt, ones, next_ones;
	logic [3:0] irq_en, ready;
	logic [2:0] mode_prev;
	logic [1:0] single_chan, phase, chan;
	logic single_mode, overrun, os_tick, bit_meta, bit_sync;
	logic frame_end, mode_change, keep;
	logic bus_req, wr_done, wr_lo, wr_hi;

	assign bus_req = avs_read_in | avs_write_in;
	assign wr_done = avs_write_in && (bus_state == sdadc_pkg::SDADC_BUS_DONE);
	assign wr_lo = wr_done && (avs_address_in == sdadc_pkg::OFS_CSR) &&
		avs_byteenable_in[0];
	assign wr_hi = wr_done && (avs_address_in == sdadc_pkg::OFS_CSR) &&
		avs_byteenable_in[1];

	// ****************************************
	// Bus handshake
	// ****************************************

	// Two wait cycles, then one answer cycle
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			bus_state <= sdadc_pkg::SDADC_BUS_IDLE;
		end else begin
			case (bus_state)
				sdadc_pkg::SDADC_BUS_IDLE: begin
					if (bus_req) begin
						bus_state <= sdadc_pkg::SDADC_BUS_WAIT;
					end
				end
				sdadc_pkg::SDADC_BUS_WAIT: begin
					bus_state <= sdadc_pkg::SDADC_BUS_DONE;
				end
				default: begin
					bus_state <= sdadc_pkg::SDADC_BUS_IDLE;
				end
			endcase
		end
	end

	assign avs_waitrequest_out = bus_req &&
		(bus_state != sdadc_pkg::SDADC_BUS_DONE);
	assign mem_if.raddr = avs_address_in[4:3];

	// Read data loaded one edge before the answer cycle
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (bus_state == sdadc_pkg::SDADC_BUS_WAIT) begin
			if (is_data(avs_address_in)) begin
				avs_readdata_out <= {16'h0000, mem_if.rdata};
			end else if (avs_address_in == sdadc_pkg::OFS_CSR) begin
				avs_readdata_out <= {18'h0, overrun, 1'b0, irq_en, 1'b0,
					single_mode, single_chan, ready};
			end else if (avs_address_in == sdadc_pkg::OFS_PWR) begin
				avs_readdata_out <= {31'h0, analog_power_out};
			end else begin
				avs_readdata_out <= 32'h0000_0000;
			end
		end
	end

	// Control fields written by software
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			divider <= sdadc_pkg::DIV_RST;
			irq_en <= 4'h0;
			single_mode <= 1'b0;
			single_chan <= 2'h0;
			analog_power_out <= 1'b0;
		end else begin
			if (wr_lo) begin
				single_mode <= avs_writedata_in[sdadc_pkg::CSR_SINGLE_BIT];
				single_chan <= avs_writedata_in[sdadc_pkg::CSR_SEL_LSB +: 2];
			end
			if (wr_hi) begin
				irq_en <= avs_writedata_in[sdadc_pkg::CSR_IE_LSB +: 4];
			end
			if (wr_done && avs_address_in == sdadc_pkg::OFS_DIV &&
				avs_byteenable_in[0] && avs_byteenable_in[1]) begin
				divider <= avs_writedata_in[11:0];
			end
			if (wr_done && avs_address_in == sdadc_pkg::OFS_PWR &&
				avs_byteenable_in[0]) begin
				analog_power_out <= avs_writedata_in[sdadc_pkg::PWR_BIT];
			end
		end
	end

	// ****************************************
	// Oversampling clock
	// ****************************************

	// Unsupported settings below two run as two
	assign div_eff = (divider < sdadc_pkg::DIV_MIN) ? sdadc_pkg::DIV_MIN :
		divider;

	// Half period of div_eff bus cycles; stopped by the clock gate
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			div_cnt <= 12'h000;
			mod_clk_out <= 1'b0;
		end else if (!clk_stop_in) begin
			if (div_cnt >= div_eff - 12'h001) begin
				div_cnt <= 12'h000;
				mod_clk_out <= ~mod_clk_out;
			end else begin
				div_cnt <= div_cnt + 12'h001;
			end
		end
	end

	assign os_tick = !clk_stop_in && !mod_clk_out &&
		(div_cnt >= div_eff - 12'h001);

	// Modulator bit synchroniser
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			bit_meta <= 1'b0;
			bit_sync <= 1'b0;
		end else begin
			bit_meta <= mod_bit_in;
			bit_sync <= bit_meta;
		end
	end

	// ****************************************
	// Frame sequencing
	// ****************************************
	assign mode_change = mode_prev != {single_mode, single_chan};
	assign frame_end = os_tick && (frame_cnt == sdadc_pkg::FRAME_LAST);
	assign keep = !single_mode || (phase == sdadc_pkg::KEEP_PHASE);
	assign next_ones = ones + {8'h00, bit_sync};

	// Frame counter, restarted by a mode change
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			frame_cnt <= 9'h000;
			mode_prev <= 3'h0;
		end else begin
			mode_prev <= {single_mode, single_chan};
			if (mode_change) begin
				frame_cnt <= 9'h000;
			end else if (os_tick) begin
				frame_cnt <= frame_cnt + 9'h001;
			end
		end
	end

	// Modulator reset during the first cycle of each frame
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			mod_reset_out <= 1'b1;
		end else begin
			mod_reset_out <= mode_change || (frame_cnt == 9'h000);
		end
	end

	// Decimation: count of ones over the frame's last 511 cycles
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ones <= 9'h000;
		end else if (mode_change ||
			(os_tick && frame_cnt == 9'h000)) begin
			ones <= 9'h000;
		end else if (os_tick && !frame_end) begin
			ones <= next_ones;
		end
	end

	// Channel and single-mode phase
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			chan <= 2'h0;
			phase <= 2'h0;
		end else if (mode_change) begin
			chan <= single_mode ? single_chan : 2'h0;
			phase <= 2'h0;
		end else if (frame_end) begin
			phase <= phase + 2'h1;
			if (!single_mode) begin
				chan <= chan + 2'h1;
			end
		end
	end

	assign mod_channel_out = chan;

	// Result write: signed, mid-scale at zero, low bits zero
	assign mem_if.we = frame_end && keep && !mode_change;
	assign mem_if.waddr = chan;
	assign mem_if.wdata = {next_ones, 7'h00} - sdadc_pkg::MID_SCALE;

	// ****************************************
	// Flags and interrupt
	// ****************************************

	// Ready flags: set wins over a software clear
	for (genvar gi = 0; gi < sdadc_pkg::NUM_CH; gi++) begin : g_ready
		always_ff @(posedge core_clk_in) begin
			if (rst_in) begin
				ready[gi] <= 1'b0;
			end else if (mem_if.we && mem_if.waddr == 2'(gi)) begin
				ready[gi] <= 1'b1;
			end else if (wr_lo &&
				!avs_writedata_in[sdadc_pkg::CSR_DA_LSB + gi]) begin
				ready[gi] <= 1'b0;
			end
		end
	end

	// Overrun: sticky, set wins over a software clear
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			overrun <= 1'b0;
		end else if (mem_if.we && ready[mem_if.waddr]) begin
			overrun <= 1'b1;
		end else if (wr_hi && !avs_writedata_in[sdadc_pkg::CSR_OVR_BIT]) begin
			overrun <= 1'b0;
		end
	end

	// Interrupt request, one cycle after the flags
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(ready & irq_en);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_frame_end;
		os_tick && frame_cnt == sdadc_pkg::FRAME_LAST && !mode_change;
	endsequence
	property p_reset_first;
		os_tick && frame_cnt == 9'h000 |=> mod_reset_out;
	endproperty
	a_reset_first: assert property (p_reset_first)
		else $error("modulator reset missing in first frame cycle");
	property p_write_at_end;
		mem_if.we |-> frame_cnt == sdadc_pkg::FRAME_LAST && os_tick;
	endproperty
	a_write_at_end: assert property (p_write_at_end)
		else $error("result written outside frame end");
	property p_rr_advance;
		s_frame_end and !single_mode |=> chan == $past(chan) + 2'h1;
	endproperty
	a_rr_advance: assert property (p_rr_advance)
		else $error("channel did not advance");
	property p_single_keep;
		mem_if.we && single_mode |-> phase == 2'h3 && chan == single_chan;
	endproperty
	a_single_keep: assert property (p_single_keep)
		else $error("single mode kept wrong frame");
	property p_tick_spacing;
		os_tick |=> !os_tick [*3];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("oversampling ticks closer than four cycles");
	property p_div_read_zero;
		avs_read_in && !avs_waitrequest_out &&
			avs_address_in == sdadc_pkg::OFS_DIV |-> avs_readdata_out == 32'h0;
	endproperty
	a_div_read_zero: assert property (p_div_read_zero)
		else $error("divider read not zero");
	property p_div_reset;
		$past(rst_in) |-> divider == sdadc_pkg::DIV_RST;
	endproperty
	a_div_reset: assert property (p_div_reset)
		else $error("divider reset value wrong");
	property p_overrun_set;
		mem_if.we && ready[mem_if.waddr] |=> overrun;
	endproperty
	a_overrun_set: assert property (p_overrun_set)
		else $error("overrun not flagged");
	property p_ready_set;
		mem_if.we |=> ready[$past(mem_if.waddr)];
	endproperty
	a_ready_set: assert property (p_ready_set)
		else $error("ready flag not set by new sample");
	property p_irq_level;
		1'b1 |=> irq_out == $past(|(ready & irq_en));
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt does not follow enabled ready flags");
endmodule : sdadc_seq

// file: sdadc_mod_model.sv
// Behavioural modulator that feeds the sequencer one bit per tick.
// Assumes the mod_* outputs of the sequencer, all on core_clk_in.
`timescale 1ns/1ps

module sdadc_mod_model (
	// Clock
	input wire logic core_clk_in,
	// From the sequencer
	input wire logic mod_clk_in,
	input wire logic mod_reset_in,
	input wire logic [1:0] mod_channel_in,
	// To the sequencer
	output logic mod_bit_out
);
	logic last_clk;

	initial begin
		last_clk = 1'b0;
		mod_bit_out = 1'b0;
	end

	// Even channels give all ones, odd all zeros; in reset the bit holds
	always @(posedge core_clk_in) begin
		last_clk <= mod_clk_in;
		if (mod_clk_in && !last_clk && !mod_reset_in) begin
			mod_bit_out <= !mod_channel_in[0];
		end
	end
endmodule : sdadc_mod_model

// file: testbench.sv
// Self-checking bench of the converter sequencer over Avalon-MM.
// Assumes sdadc_pkg, sdadc_seq and the modulator model are compiled.
`timescale 1ns/1ps

module testbench;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [5:0] avs_address_in = 6'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [3:0] avs_byteenable_in = 4'hf;
	logic [31:0] avs_writedata_in = 32'h0;
	logic clk_stop_in = 1'b0;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out, mod_bit_in, mod_clk_out, mod_reset_out;
	logic analog_power_out, irq_out, mclk_d;
	logic [1:0] mod_channel_out, chan_d;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	int rise_at = 0;
	int rise_gap = 0;
	int chan_at = 0;
	int chan_gap = 0;
	int rst_cnt = 0;
	int rst_len = 0;

	sdadc_seq u_sdadc_seq (.core_clk_in, .rst_in, .avs_address_in,
		.avs_read_in, .avs_write_in, .avs_byteenable_in, .avs_writedata_in,
		.avs_readdata_out, .avs_waitrequest_out, .mod_bit_in, .mod_clk_out,
		.mod_reset_out, .mod_channel_out, .clk_stop_in, .analog_power_out,
		.irq_out);

	sdadc_mod_model u_sdadc_mod_model (.core_clk_in(core_clk_in),
		.mod_clk_in(mod_clk_out), .mod_reset_in(mod_reset_out),
		.mod_channel_in(mod_channel_out), .mod_bit_out(mod_bit_in));

	// 20 MHz clock and a cycle count
	always #25 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) cyc <= cyc + 1;

	// Times of ticks, channel changes and modulator reset length
	always @(negedge core_clk_in) begin
		mclk_d <= mod_clk_out;
		chan_d <= mod_channel_out;
		if (mod_clk_out === 1'b1 && mclk_d === 1'b0) begin
			rise_gap <= cyc - rise_at;
			rise_at <= cyc;
		end
		if (mod_channel_out !== chan_d) begin
			chan_gap <= cyc - chan_at;
			chan_at <= cyc;
		end
		if (mod_reset_out === 1'b1) begin
			rst_cnt <= rst_cnt + 1;
		end else begin
			if (rst_cnt != 0) rst_len <= rst_cnt;
			rst_cnt <= 0;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t ns %s: got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// One bus cycle, held until waitrequest is sampled low at a rising edge
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
		input logic [3:0] be, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge core_clk_in);
		avs_address_in <= a;
		avs_read_in <= !wr;
		avs_write_in <= wr;
		avs_writedata_in <= wd;
		avs_byteenable_in <= be;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 16);
		rd = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (n >= 16) chk(32'h1, 32'h0, "bus timeout");
	endtask : bus

	task wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, 4'hf, x);
	endtask : wr

	task rd_chk(input logic [5:0] a, input logic [31:0] m,
		input logic [31:0] e, input string what);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, 4'hf, d);
		chk(d & m, e, what);
	endtask : rd_chk

	// Poll the status register until a ready flag shows
	task wait_ready(output logic [31:0] d);
		int t0;
		t0 = cyc;
		do begin
			bus(1'b0, sdadc_pkg::OFS_CSR, 32'h0, 4'hf, d);
		end while (d[3:0] === 4'h0 && cyc - t0 < 12000);
	endtask : wait_ready

	task t_reset;
		for (int c = 0; c < 4; c++) begin
			rd_chk(6'(c * 8), 32'hffffffff, 32'h0, "result reset");
		end
		rd_chk(sdadc_pkg::OFS_CSR, 32'hffffffff, 32'h0, "csr reset");
		rd_chk(sdadc_pkg::OFS_DIV, 32'hffffffff, 32'h0, "div read");
		rd_chk(6'h28, 32'hffffffff, 32'h0, "unmapped read");
		wr(sdadc_pkg::OFS_DATA0, 32'hffff);
		rd_chk(sdadc_pkg::OFS_DATA0, 32'hffff, 32'h0, "result write");
		chk({31'h0, analog_power_out}, 32'h0, "power reset");
		chk({31'h0, irq_out}, 32'h0, "irq reset");
		repeat (40) @(posedge core_clk_in);
		chk(rise_gap, 32'd10, "reset divider");
		$display("Test reset done");
	endtask : t_reset

	task t_round_robin;
		logic [1:0] ch;
		logic [31:0] x;
		// Fastest legal rate keeps frames short
		wr(sdadc_pkg::OFS_DIV, 32'h2);
		bus(1'b1, sdadc_pkg::OFS_DIV, 32'h7, 4'h1, x); // Lane 0 alone refused
		wr(sdadc_pkg::OFS_PWR, 32'h1);
		wr(sdadc_pkg::OFS_CSR, 32'h0f00);
		repeat (20) @(posedge core_clk_in);
		chk(rise_gap, 32'd4, "divide by four");
		chk({31'h0, analog_power_out}, 32'h1, "power on");
		for (int k = 0; k < 5; k++) begin
			ch = mod_channel_out;
			@(posedge core_clk_in);
			while (mod_channel_out === ch && cyc < 30000) @(posedge core_clk_in);
			if (k > 0) chk(chan_gap, 32'd2048, "frame length");
			chk({30'h0, mod_channel_out}, {30'h0, ch + 2'h1}, "next");
		end
		chk(rst_len, 32'd4, "reset one tick");
		for (int c = 0; c < 4; c++) begin
			rd_chk(6'(c * 8), 32'hfff0, (c % 2) ? 32'h8000 : 32'h7f80,
				"result");
		end
		rd_chk(sdadc_pkg::OFS_CSR, 32'h0fff, 32'h0f0f, "ready all");
		chk({31'h0, irq_out}, 32'h1, "irq on");
		repeat (8300) @(posedge core_clk_in);
		rd_chk(sdadc_pkg::OFS_CSR, 32'h2000, 32'h2000, "overrun");
		$display("Test round robin done");
	endtask : t_round_robin

	task t_flags;
		int t;
		// Analog section off before the low-power stop
		wr(sdadc_pkg::OFS_PWR, 32'h0);
		rd_chk(sdadc_pkg::OFS_PWR, 32'h1, 32'h0, "power off");
		@(posedge core_clk_in);
		clk_stop_in <= 1'b1;
		repeat (8) @(posedge core_clk_in);
		t = rise_at;
		repeat (100) @(posedge core_clk_in);
		chk(rise_at, t, "clock gated");
		wr(sdadc_pkg::OFS_CSR, 32'h2f00);
		rd_chk(sdadc_pkg::OFS_CSR, 32'hffff, 32'h2f00, "ready cleared");
		chk({31'h0, irq_out}, 32'h0, "irq off");
		wr(sdadc_pkg::OFS_CSR, 32'h0f0f);
		rd_chk(sdadc_pkg::OFS_CSR, 32'hffff, 32'h0f00, "overrun cleared");
		$display("Test flags done");
	endtask : t_flags

	task t_single;
		logic [31:0] d;
		int t0;
		// Channel 2 alone, interrupt enabled for channel 1 only
		wr(sdadc_pkg::OFS_CSR, 32'h0260);
		clk_stop_in <= 1'b0;
		repeat (8) @(posedge core_clk_in);
		chk({30'h0, mod_channel_out}, 32'h2, "selected channel");
		wait_ready(d);
		t0 = cyc;
		chk(d & 32'hf, 32'h4, "only channel 2");
		chk({31'h0, irq_out}, 32'h0, "masked irq");
		wr(sdadc_pkg::OFS_CSR, 32'h0260);
		wait_ready(d);
		chk({31'h0, (cyc - t0 > 8180) && (cyc - t0 < 8204)}, 32'h1,
			"one of four");
		rd_chk(sdadc_pkg::OFS_DATA2, 32'hfff0, 32'h7f80, "single result");
		// Ready bit of channel 2 written as one so it stays set
		wr(sdadc_pkg::OFS_CSR, 32'h0464);
		repeat (3) @(posedge core_clk_in);
		chk({31'h0, irq_out}, 32'h1, "enabled irq");
		$display("Test single done");
	endtask : t_single

	task conclude;
		$display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	// Main sequence
	initial begin
		repeat (10) @(posedge core_clk_in);
		rst_in <= 1'b0;
		t_reset;
		t_round_robin;
		t_flags;
		t_single;
		conclude;
	end

	// Watchdog well past the expected run
	initial begin
		repeat (90000) @(posedge core_clk_in);
		n_mismatch++;
		conclude;
	end
endmodule : testbench
